// file: design/rsip_pkg.sv
// Constants, types and states of the ranging sensor serial controller.
// ============================================================
package rsip_pkg;

    // ============================================================
    // Addresses and byte layout
    localparam logic [7:0] ADDR_WR     = 8'h52;
    localparam logic [7:0] ADDR_RD     = 8'h53;
    localparam logic [3:0] ACK_BIT     = 4'h8;
    localparam logic [3:0] SEQ_ADDR    = 4'h0;
    localparam logic [3:0] SEQ_IDX_HI  = 4'h1;
    localparam logic [3:0] SEQ_IDX_LO  = 4'h2;
    localparam logic [3:0] SEQ_DATA    = 4'h3;
    localparam logic [3:0] SEQ_RD_DATA = 4'h4;
    localparam logic [1:0] LEN_MAX_M1  = 2'h3;

    // ============================================================
    // Quarter phases of one SCL bit
    localparam logic [1:0] Q0 = 2'h0;
    localparam logic [1:0] Q1 = 2'h1;
    localparam logic [1:0] Q2 = 2'h2;
    localparam logic [1:0] Q3 = 2'h3;

    // ============================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_PERIOD_NS = 1000;
    localparam int QTR_CYC       = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
    localparam int BOOT_TIME_NS  = 1200000;
    localparam int BOOT_CYC      = (BOOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W         = 17;

    // ============================================================
    // Types
    typedef enum logic [2:0] {
        ST_STANDBY,
        ST_BOOT,
        ST_IDLE,
        ST_START,
        ST_BYTE,
        ST_STOP
    } rsip_state_t;

    typedef struct packed {
        logic        rd;
        logic [1:0]  len_m1;
        logic [15:0] index;
        logic [31:0] wdata;
    } rsip_cmd_t;

    typedef struct packed {
        logic        nack;
        logic [31:0] rdata;
    } rsip_rsp_t;

endpackage

// file: design/rsip_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pin inputs.
`timescale 1ns/1ns
module rsip_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_q;

    // Idle level of open-drain lines is high, so reset to ones
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '1;
            q_o    <= '1;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end

endmodule

// file: design/rsip_timer.sv
// Loadable down counter used for quarter-bit ticks and boot wait.
`timescale 1ns/1ns
module rsip_timer (
    input  wire logic                       clk_sys_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       load_i,
    input  wire logic [rsip_pkg::TMR_W-1:0] value_i,
    output logic                            zero_o
);

    logic [rsip_pkg::TMR_W-1:0] cnt_q;

    // Load wins over counting; stops at zero
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
        end else if (load_i) begin
            cnt_q <= value_i;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign zero_o = (cnt_q == '0);

endmodule

// file: design/rsip_host_ctrl.sv
// Serial bus controller that reaches the ranging sensor registers.
`timescale 1ns/1ns
module rsip_host_ctrl #(
    parameter int BOOT_CYCLES = rsip_pkg::BOOT_CYC
) (
    input  wire logic                clk_sys_i,
    input  wire logic                rst_n_i,
    input  wire logic                cmd_valid_i,
    input  wire rsip_pkg::rsip_cmd_t cmd_i,
    output logic                     cmd_ready_o,
    output logic                     rsp_valid_o,
    output rsip_pkg::rsip_rsp_t      rsp_o,
    input  wire logic                shutdown_req_i,
    output logic                     standby_o,
    output logic                     booting_o,
    output logic                     result_ready_o,
    output logic                     shutdown_n_pin_o,
    input  wire logic                result_irq_pin_i,
    input  wire logic                scl_i,
    output logic                     scl_o,
    output logic                     scl_oe_n_o,
    input  wire logic                sda_i,
    output logic                     sda_o,
    output logic                     sda_oe_n_o
);

    localparam int SCL_HIGH_MIN = 2 * rsip_pkg::QTR_CYC;
    localparam logic [rsip_pkg::TMR_W-1:0] QTR_LOAD = rsip_pkg::TMR_W'(rsip_pkg::QTR_CYC - 1);
    localparam logic [rsip_pkg::TMR_W-1:0] BOOT_LOAD = rsip_pkg::TMR_W'(BOOT_CYCLES - 1);

    rsip_pkg::rsip_state_t state_q;
    rsip_pkg::rsip_cmd_t   cmd_q;
    logic [1:0]  q_q;
    logic [3:0]  bit_q;
    logic [3:0]  seq_q;
    logic [7:0]  sh_q;
    logic [31:0] wr_q;
    logic [31:0] rd_q;
    logic        rep_q;
    logic        rxbit_q;
    logic        err_q;
    logic        rsp_valid_q;
    logic        scl_drive_q;
    logic        sda_drive_q;
    logic        shutdown_n_q;
    logic [7:0]  rel_cnt_q;
    logic        scl_d;
    logic        sda_d;
    logic        scl_s;
    logic        sda_s;
    logic        irq_s;
    logic        bus;
    logic        qzero;
    logic        tick;
    logic        tick_en;
    logic        qend;
    logic        boot_zero;
    logic        is_rx;
    logic        last_rx;
    logic        last_tx;
    logic        byte_end;
    logic        nack_hit;
    logic        go_rstart;
    logic        go_next;
    logic        start_done;
    logic        load_sh;
    logic [3:0]  load_seq;
    logic [7:0]  tx_byte;
    logic        accept;

    // ============================================================
    // Pin synchronisers and timers
    rsip_sync #(
        .W (3)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .d_i       ({scl_i, sda_i, result_irq_pin_i}),
        .q_o       ({scl_s, sda_s, irq_s})
    );

    // Quarter ticks run only while a message is on the bus
    rsip_timer u_qtr (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .load_i    (!bus || tick),
        .value_i   (QTR_LOAD),
        .zero_o    (qzero)
    );

    // Boot wait reloads until the shutdown pin is out high, so it counts from the pin's rise
    rsip_timer u_boot (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .load_i    ((state_q == rsip_pkg::ST_STANDBY) || !shutdown_n_q),
        .value_i   (BOOT_LOAD),
        .zero_o    (boot_zero)
    );

    // ============================================================
    // Sequencing terms
    assign bus     = (state_q == rsip_pkg::ST_START) || (state_q == rsip_pkg::ST_BYTE) ||
                     (state_q == rsip_pkg::ST_STOP);
    assign tick    = bus && qzero;
    // Sensor may hold SCL low; wait for the line before the high half
    assign tick_en = tick && !(q_q == rsip_pkg::Q2 && !scl_s);
    assign qend    = tick_en && (q_q == rsip_pkg::Q3);
    assign is_rx   = cmd_q.rd && (seq_q >= rsip_pkg::SEQ_RD_DATA);
    assign last_rx = (seq_q == rsip_pkg::SEQ_RD_DATA + {2'b00, cmd_q.len_m1});
    assign last_tx = (seq_q == rsip_pkg::SEQ_DATA + {2'b00, cmd_q.len_m1});
    assign byte_end   = (state_q == rsip_pkg::ST_BYTE) && qend && (bit_q == rsip_pkg::ACK_BIT);
    // Sensor silence on a sent byte ends the message, sleeping or not
    assign nack_hit   = byte_end && !is_rx && rxbit_q;
    // Index goes in a write message, then a repeated start turns it round
    assign go_rstart  = byte_end && !nack_hit && cmd_q.rd &&
                        (seq_q == rsip_pkg::SEQ_IDX_LO);
    assign go_next    = byte_end && !nack_hit && !go_rstart && !(is_rx && last_rx) &&
                        !(!cmd_q.rd && last_tx);
    assign start_done = (state_q == rsip_pkg::ST_START) && qend;
    assign load_sh    = start_done || go_next;
    assign load_seq   = start_done ? seq_q : seq_q + 4'h1;
    assign accept     = cmd_valid_i && cmd_ready_o;

    // Byte to send at each step of the message
    always_comb begin
        case (load_seq)
            rsip_pkg::SEQ_ADDR:   tx_byte = rsip_pkg::ADDR_WR;
            rsip_pkg::SEQ_IDX_HI: tx_byte = cmd_q.index[15:8];
            rsip_pkg::SEQ_IDX_LO: tx_byte = cmd_q.index[7:0];
            rsip_pkg::SEQ_DATA:   tx_byte = cmd_q.rd ? rsip_pkg::ADDR_RD : wr_q[31:24];
            default:              tx_byte = wr_q[31:24];
        endcase
    end

    // ============================================================
    // Main state machine
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= rsip_pkg::ST_STANDBY;
        end else begin
            case (state_q)
                rsip_pkg::ST_STANDBY: begin
                    if (!shutdown_req_i) begin
                        state_q <= rsip_pkg::ST_BOOT;
                    end
                end
                // No traffic until boot has surely ended
                rsip_pkg::ST_BOOT: begin
                    if (boot_zero) begin
                        state_q <= rsip_pkg::ST_IDLE;
                    end
                end
                rsip_pkg::ST_IDLE: begin
                    if (shutdown_req_i) begin
                        state_q <= rsip_pkg::ST_STANDBY;
                    end else if (cmd_valid_i) begin
                        state_q <= rsip_pkg::ST_START;
                    end
                end
                rsip_pkg::ST_START: begin
                    if (qend) begin
                        state_q <= rsip_pkg::ST_BYTE;
                    end
                end
                rsip_pkg::ST_BYTE: begin
                    if (go_rstart) begin
                        state_q <= rsip_pkg::ST_START;
                    end else if (byte_end && !go_next) begin
                        state_q <= rsip_pkg::ST_STOP;
                    end
                end
                rsip_pkg::ST_STOP: begin
                    if (qend) begin
                        state_q <= rsip_pkg::ST_IDLE;
                    end
                end
                default: state_q <= rsip_pkg::ST_STANDBY;
            endcase
        end
    end

    // Quarter phase wraps naturally through four steps per bit
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_q <= rsip_pkg::Q0;
        end else if (!bus) begin
            q_q <= rsip_pkg::Q0;
        end else if (tick_en) begin
            q_q <= q_q + 2'h1;
        end
    end

    // Bit and byte counters, repeated start marker
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_q <= '0;
            seq_q <= '0;
            rep_q <= 1'b0;
        end else if (accept) begin
            seq_q <= rsip_pkg::SEQ_ADDR;
            rep_q <= 1'b0;
        end else if (go_rstart) begin
            seq_q <= rsip_pkg::SEQ_DATA;
            rep_q <= 1'b1;
        end else if (load_sh) begin
            bit_q <= '0;
            seq_q <= load_seq;
        end else if ((state_q == rsip_pkg::ST_BYTE) && qend && (bit_q != rsip_pkg::ACK_BIT)) begin
            bit_q <= bit_q + 4'h1;
        end
    end

    // Command latch
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd_q <= '0;
        end else if (accept) begin
            cmd_q <= cmd_i;
        end
    end

    // Write data left aligned so the top byte goes to the lowest index
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_q <= '0;
        end else if (accept) begin
            wr_q <= cmd_i.wdata << {rsip_pkg::LEN_MAX_M1 - cmd_i.len_m1, 3'b000};
        end else if (load_sh && !cmd_q.rd && (load_seq >= rsip_pkg::SEQ_DATA)) begin
            wr_q <= {wr_q[23:0], 8'h00};
        end
    end

    // Shift register: sent MSB first, received bits shifted in after the high half
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sh_q <= '0;
        end else if (load_sh) begin
            sh_q <= tx_byte;
        end else if ((state_q == rsip_pkg::ST_BYTE) && qend && (bit_q != rsip_pkg::ACK_BIT)) begin
            sh_q <= {sh_q[6:0], rxbit_q};
        end
    end

    // Data line sampled once SCL is seen high
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rxbit_q <= 1'b1;
        end else if (tick_en && (q_q == rsip_pkg::Q2)) begin
            rxbit_q <= sda_s;
        end
    end

    // Read bytes gather most significant first into the low end
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_q <= '0;
        end else if (accept) begin
            rd_q <= '0;
        end else if (byte_end && is_rx) begin
            rd_q <= {rd_q[23:0], sh_q};
        end
    end

    // Missing acknowledge flag and response pulse
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            err_q       <= 1'b0;
            rsp_valid_q <= 1'b0;
        end else begin
            rsp_valid_q <= (state_q == rsip_pkg::ST_STOP) && qend;
            if (accept) begin
                err_q <= 1'b0;
            end else if (nack_hit) begin
                err_q <= 1'b1;
            end
        end
    end

    // ============================================================
    // Line drive: 1 means pull low
    always_comb begin
        scl_d = 1'b0;
        sda_d = 1'b0;
        case (state_q)
            rsip_pkg::ST_START: begin
                scl_d = rep_q && (q_q == rsip_pkg::Q0 || q_q == rsip_pkg::Q1);
                sda_d = (q_q == rsip_pkg::Q3);
            end
            rsip_pkg::ST_BYTE: begin
                scl_d = (q_q == rsip_pkg::Q0 || q_q == rsip_pkg::Q1);
                if (bit_q == rsip_pkg::ACK_BIT) begin
                    sda_d = is_rx && !last_rx;
                end else begin
                    sda_d = !is_rx && !sh_q[7];
                end
            end
            rsip_pkg::ST_STOP: begin
                scl_d = (q_q == rsip_pkg::Q0 || q_q == rsip_pkg::Q1);
                sda_d = (q_q != rsip_pkg::Q3);
            end
            default: begin
                scl_d = 1'b0;
                sda_d = 1'b0;
            end
        endcase
    end

    // SDA held through the first quarter so it never moves with the SCL fall
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_drive_q <= 1'b0;
            sda_drive_q <= 1'b0;
        end else begin
            scl_drive_q <= scl_d;
            if (q_q != rsip_pkg::Q0) begin
                sda_drive_q <= sda_d;
            end
        end
    end

    // Shutdown pin low for standby, raised to start boot
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shutdown_n_q <= 1'b0;
        end else begin
            shutdown_n_q <= (state_q != rsip_pkg::ST_STANDBY);
        end
    end

    // ============================================================
    // Outputs
    assign scl_o            = 1'b0;
    assign sda_o            = 1'b0;
    assign scl_oe_n_o       = !scl_drive_q;
    assign sda_oe_n_o       = !sda_drive_q;
    assign cmd_ready_o      = (state_q == rsip_pkg::ST_IDLE) && !shutdown_req_i;
    assign rsp_valid_o      = rsp_valid_q;
    assign rsp_o.nack       = err_q;
    assign rsp_o.rdata      = rd_q;
    assign standby_o        = (state_q == rsip_pkg::ST_STANDBY);
    assign booting_o        = (state_q == rsip_pkg::ST_BOOT);
    // Open-drain interrupt seen low means result waiting
    // Software clears the result through a register write; ranging holds meanwhile
    assign result_ready_o   = !irq_s;
    assign shutdown_n_pin_o = shutdown_n_q;

    // ============================================================
    // Checks
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rel_cnt_q <= '0;
        end else if (scl_drive_q) begin
            rel_cnt_q <= '0;
        end else if (rel_cnt_q != 8'hff) begin
            rel_cnt_q <= rel_cnt_q + 8'h01;
        end
    end

    AST_SDA_STABLE_HIGH: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (state_q == rsip_pkg::ST_BYTE) && !scl_drive_q && !$past(scl_drive_q) |-> $stable(sda_drive_q))
        else $error("SDA moved while SCL high");
    AST_START_ONLY_FALL: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(sda_drive_q) && !scl_drive_q |-> state_q == rsip_pkg::ST_START)
        else $error("SDA fell under high SCL outside start");
    AST_STOP_ONLY_RISE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $fell(sda_drive_q) && !scl_drive_q |-> $past(state_q) == rsip_pkg::ST_STOP)
        else $error("SDA rose under high SCL outside stop");
    AST_FIRST_ADDR: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(state_q == rsip_pkg::ST_BYTE) && seq_q == rsip_pkg::SEQ_ADDR |-> sh_q == rsip_pkg::ADDR_WR)
        else $error("first byte is not the write address");
    AST_READ_ADDR: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(state_q == rsip_pkg::ST_BYTE) && cmd_q.rd && seq_q == rsip_pkg::SEQ_DATA
        |-> sh_q == rsip_pkg::ADDR_RD)
        else $error("read message lacks read address");
    AST_BIT_LIMIT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        byte_end |-> ##1 (bit_q == 4'h0 || state_q != rsip_pkg::ST_BYTE))
        else $error("byte did not close after nine slots");
    AST_RX_RELEASE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        state_q == rsip_pkg::ST_BYTE && is_rx && bit_q != rsip_pkg::ACK_BIT && q_q == rsip_pkg::Q2
        |-> !sda_drive_q)
        else $error("host drives SDA during read data");
    AST_HOST_ACK: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        state_q == rsip_pkg::ST_BYTE && is_rx && bit_q == rsip_pkg::ACK_BIT && q_q == rsip_pkg::Q2
        |-> sda_drive_q == !last_rx)
        else $error("wrong host acknowledge on read byte");
    AST_SCL_HIGH_TIME: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(scl_drive_q) |-> rel_cnt_q >= SCL_HIGH_MIN)
        else $error("SCL high time too short");
    AST_NO_CMD_ASLEEP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        state_q == rsip_pkg::ST_STANDBY || state_q == rsip_pkg::ST_BOOT
        |-> !cmd_ready_o && !scl_drive_q && !sda_drive_q)
        else $error("bus activity in standby or boot");
    AST_BOOT_WAIT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(state_q == rsip_pkg::ST_BOOT) |-> (state_q == rsip_pkg::ST_BOOT)[*8] ##0 shutdown_n_q)
        else $error("boot wait cut short");
    AST_RSP_AFTER_STOP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        rsp_valid_o |-> $past(state_q) == rsip_pkg::ST_STOP && state_q == rsip_pkg::ST_IDLE)
        else $error("response without closing stop");

endmodule

// file: verif/rsip_sensor_model.sv
// Behavioural ranging sensor: serial target, result pin, shutdown pin.
`timescale 1ns/1ns
module rsip_sensor_model #(
    parameter int          BOOT_NS = 100,
    parameter logic [15:0] CLR_IDX = 16'h0086 // Clear index, arbitrary
) (
    input  wire logic scl_i,
    input  wire logic sda_i,
    input  wire logic shutdown_n_pin_i,
    input  wire logic result_set_i,
    input  wire logic deaf_i,
    input  wire logic stretch_i,
    output logic      scl_oe_n_o,
    output logic      sda_oe_n_o,
    output logic      result_irq_oe_n_o
);
    logic [7:0]  mem [0:255];
    logic [15:0] idx;
    logic [7:0]  sh, tx;
    logic [3:0]  bc;
    logic [2:0]  ph;
    logic        act, up, ok;
    // ============================================================
    // Power and result pin
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'ha5;
        {act, up, bc, ph, idx} = '0;
        {scl_oe_n_o, sda_oe_n_o, result_irq_oe_n_o} = 3'b111;
    end
    always @(posedge shutdown_n_pin_i) begin
        #(BOOT_NS);
        up = shutdown_n_pin_i;
    end
    always @(negedge shutdown_n_pin_i) up = 0;
    // One pending result blocks the next until cleared
    always @(posedge result_set_i) result_irq_oe_n_o = 0;
    // ============================================================
    // Serial target; a target that is not up never answers
    always @(negedge sda_i) if (scl_i) begin
        act = up;
        bc = 0;
        ph = 0;
    end
    always @(posedge sda_i) if (scl_i) act = 0;
    always @(posedge scl_i) if (act) begin
        if (bc < 8) sh = {sh[6:0], sda_i};
        else if (ph == 4 && sda_i) act = 0;
        bc = (bc == 8) ? 4'h0 : bc + 4'h1;
    end
    always @(negedge scl_i) begin
        if (act && bc == 8 && ph != 4) begin
            ok = !deaf_i;
            case (ph)
                0: begin ok = ok && sh[7:1] == 7'h29; ph = sh[0] ? 3'h4 : 3'h1; end
                1: begin idx[15:8] = sh; ph = 2; end
                2: begin idx[7:0] = sh; ph = 3; end
                default: begin
                    mem[idx[7:0]] = sh;
                    if (idx == CLR_IDX) result_irq_oe_n_o = 1;
                    idx++;
                end
            endcase
            sda_oe_n_o = !ok;
            act = ok;
        end else if (act && ph == 4 && bc < 8) begin
            if (bc == 0) tx = mem[idx[7:0]];
            sda_oe_n_o = tx[7 - bc];
            if (bc == 7) idx++;
        end else sda_oe_n_o = 1;
        // Slow answer holds the clock low past the host's release, so the host must wait
        if (stretch_i) begin scl_oe_n_o = 0; #800; scl_oe_n_o = 1; end
    end
endmodule

// file: verif/rsip_host_ctrl_tb_top.sv
// Self-checking bench of the serial controller against the sensor model.
`timescale 1ns/1ns
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin num_errors++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module rsip_host_ctrl_tb_top;
    logic clk_sys_i = 0, rst_n_i = 0, cmd_valid_i = 0, shutdown_req_i = 0;
    logic set_q = 0, deaf_q = 0, slow_q = 0;
    rsip_pkg::rsip_cmd_t cmd_i = '0;
    rsip_pkg::rsip_rsp_t rsp_o;
    logic cmd_ready_o, rsp_valid_o, standby_o, booting_o, result_ready_o, shutdown_n_pin_o;
    logic irq_n, scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, m_scl_n, m_sda_n;
    logic [15:0] ix;
    logic [1:0]  l;
    logic [31:0] wd;
    logic [7:0]  shadow [0:255];
    int num_errors = 0, tests_run = 0, seed = 98;
    // Open-drain wires with pull-up
    wire scl = scl_oe_n_o & m_scl_n;
    wire sda = sda_oe_n_o & m_sda_n;
    always #5 clk_sys_i = ~clk_sys_i;
    rsip_host_ctrl #(.BOOT_CYCLES(20)) rsip_host_ctrl_inst (.clk_sys_i, .rst_n_i, .cmd_valid_i,
        .cmd_i, .cmd_ready_o, .rsp_valid_o, .rsp_o, .shutdown_req_i, .standby_o, .booting_o,
        .result_ready_o, .shutdown_n_pin_o, .result_irq_pin_i(irq_n), .scl_i(scl), .scl_o,
        .scl_oe_n_o, .sda_i(sda), .sda_o, .sda_oe_n_o);
    rsip_sensor_model rsip_sensor_model_inst (.scl_i(scl), .sda_i(sda),
        .shutdown_n_pin_i(shutdown_n_pin_o), .result_set_i(set_q), .deaf_i(deaf_q),
        .stretch_i(slow_q), .scl_oe_n_o(m_scl_n), .sda_oe_n_o(m_sda_n),
        .result_irq_oe_n_o(irq_n));
    task automatic summarize();
        $display("counts: %0d compared, %0d mismatched", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Bounded wait for a flag sampled at the clock edge: 0 ready, 1 response, 2 standby
    task automatic await(input int w);
        int n;
        logic s;
        for (n = 0; n < 30000; n++) begin
            s = (w == 0) ? cmd_ready_o : (w == 1) ? rsp_valid_o : standby_o;
            if (s === 1'b1) break;
            @(posedge clk_sys_i);
        end
        if (n == 30000) begin num_errors++; summarize(); end
    endtask
    task automatic xfer(input logic rd, input logic [1:0] ln, input logic [15:0] a,
                        input logic [31:0] d);
        @(posedge clk_sys_i);
        cmd_valid_i <= 1;
        cmd_i <= '{rd: rd, len_m1: ln, index: a, wdata: d};
        @(posedge clk_sys_i);
        await(0);
        cmd_valid_i <= 0;
        await(1);
        `CHK("lines idle", 2'b11, {scl, sda})
    endtask
    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        logic [31:0] v;
        for (int k = 0; k < 4; k++) v = {v[23:0], shadow[8'(a + k)]};
        return v;
    endfunction
    initial begin
        for (int i = 0; i < 256; i++) shadow[i] = i[7:0] ^ 8'ha5;
        repeat (12) @(posedge clk_sys_i);
        `CHK("standby", 1'b1, standby_o)
        `CHK("pin low", 1'b0, shutdown_n_pin_o)
        rst_n_i <= 1;
        repeat (3) @(posedge clk_sys_i);
        `CHK("booting", 1'b1, booting_o)
        await(0);
        `CHK("pin up", 1'b1, shutdown_n_pin_o)
        `CHK("boot over", 1'b0, booting_o)
        `CHK("drive low", 2'b00, {scl_o, sda_o})
        $display("test boot done");
        for (int t = 0; t < 4; t++) begin
            ix = $random(seed);
            l = $random(seed);
            wd = $random(seed);
            slow_q <= t[0];
            xfer(0, l, ix, wd);
            `CHK("wr nack", 1'b0, rsp_o.nack)
            for (int k = 0; k <= l; k++) shadow[8'(ix[7:0] + k)] = wd[8 * (l - k) +: 8];
            xfer(1, 2'h3, ix - 16'h0001, 32'h0000_0000);
            `CHK("rd data", exp_rd(ix[7:0] - 8'h01), rsp_o.rdata)
            $display("test rw %0d done", t);
        end
        set_q <= 1;
        repeat (5) @(posedge clk_sys_i);
        `CHK("result ready", 1'b1, result_ready_o)
        xfer(0, 2'h0, 16'h0086, 32'h0000_0001);
        `CHK("result clear", 1'b0, result_ready_o)
        deaf_q <= 1;
        xfer(1, 2'h1, 16'h0010, 32'h0000_0000);
        `CHK("nack", 1'b1, rsp_o.nack)
        deaf_q <= 0;
        $display("test irq and nack done");
        shutdown_req_i <= 1;
        await(2);
        // Pin register follows the standby state one cycle later
        @(posedge clk_sys_i);
        `CHK("off pin", 1'b0, shutdown_n_pin_o)
        shutdown_req_i <= 0;
        await(0);
        xfer(1, 2'h0, 16'h0005, 32'h0000_0000);
        `CHK("wake read", 32'(shadow[5]), rsp_o.rdata)
        $display("test shutdown done");
        summarize();
    end
endmodule
